// *** shared/cbg_pkg.sv ***
package cbg_pkg;

  // Oscillator division that yields one processor clock period.
  localparam int unsigned CLK_DIV      = 9;
  localparam int unsigned DIV_W        = 4;
  // Phase windows inside the nine-count period; the gaps keep them apart.
  localparam logic [3:0]  PHI1_FIRST   = 4'h0;
  localparam logic [3:0]  PHI1_LAST    = 4'h1;
  localparam logic [3:0]  PHI2_FIRST   = 4'h3;
  localparam logic [3:0]  PHI2_LAST    = 4'h7;
  localparam logic [3:0]  DIV_LAST     = 4'h8;

  // Two flip-flops on every pin that comes from the backplane.
  localparam int unsigned SYNC_STAGES  = 2;

  // Processor status word bit positions, as latched at the status strobe.
  localparam int unsigned ST_INT_ACK_STATUS      = 0;
  localparam int unsigned ST_WO_N      = 1;
  localparam int unsigned ST_STACK     = 2;
  localparam int unsigned ST_HLTA      = 3;
  localparam int unsigned ST_OUT       = 4;
  localparam int unsigned ST_M1        = 5;
  localparam int unsigned ST_INP       = 6;
  localparam int unsigned ST_MEMR      = 7;
  localparam logic [7:0]  STATUS_RST   = 8'h00;

  // Decoder select indexes: {io, A11, A10}.
  localparam logic [2:0]  SEL_ROM0     = 3'h0;
  localparam logic [2:0]  SEL_ROM1     = 3'h1;
  localparam logic [2:0]  SEL_ROM2     = 3'h2;
  localparam logic [2:0]  SEL_RAM      = 3'h3;
  localparam logic [2:0]  SEL_SERIAL   = 3'h4;
  localparam logic [2:0]  SEL_BAUD     = 3'h5;
  localparam logic [2:0]  SEL_RTC      = 3'h6;
  localparam logic [2:0]  SEL_STEP     = 3'h7;
  localparam int unsigned ADDR_A10     = 10;
  localparam logic [3:0]  ONBOARD_HIGH = 4'h0;

  // Restart opcode skeleton; the vector number sits in bits 5:3.
  localparam logic [7:0]  RST_BASE     = 8'hC7;

  // Instruction fetches between arming single step and its interrupt.
  localparam logic [1:0]  STEP_FETCHES = 2'h2;

endpackage : cbg_pkg

// *** rtl/cbg_clkgen.sv ***
`timescale 1ns/1ps
module cbg_clkgen (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Two processor clock phases and their rising-edge ticks.
  output logic      phi1,
  output logic      phi2,
  output logic      phi1_rise,
  output logic      phi2_rise
);

  logic [3:0] div_ff;
  logic [3:0] nxt_div;
  logic       phi1_ff;
  logic       phi2_ff;
  logic       p1r_ff;
  logic       p2r_ff;
  wire        div_wrap = (div_ff == cbg_pkg::DIV_LAST);
  wire        p1_win   = (div_ff >= cbg_pkg::PHI1_FIRST) && (div_ff <= cbg_pkg::PHI1_LAST);
  wire        p2_win   = (div_ff >= cbg_pkg::PHI2_FIRST) && (div_ff <= cbg_pkg::PHI2_LAST);

  // Divide by nine; both phases decode the count so they never overlap.
  assign nxt_div = div_wrap ? 4'h0 : div_ff + 4'h1;

  // Phases are registered so the processor sees glitch-free clocks.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff  <= 4'h0;
      phi1_ff <= 1'b0;
      phi2_ff <= 1'b0;
      p1r_ff  <= 1'b0;
      p2r_ff  <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      phi1_ff <= p1_win;
      phi2_ff <= p2_win;
      p1r_ff  <= p1_win && !phi1_ff;
      p2r_ff  <= p2_win && !phi2_ff;
    end
  end

  assign phi1      = phi1_ff;
  assign phi2      = phi2_ff;
  assign phi1_rise = p1r_ff;
  assign phi2_rise = p2r_ff;

endmodule : cbg_clkgen

// *** rtl/cbg_glue.sv ***
`timescale 1ns/1ps
module cbg_glue (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Processor side, same clock domain.
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_dout,
  input  wire logic        cpu_sync,
  input  wire logic        cpu_dbin,
  input  wire logic        cpu_wr_n,
  output logic [7:0]       cpu_din,
  output logic             cpu_ready,
  output logic             cpu_reset,
  output logic             cpu_int,
  output logic             cpu_phi1,
  output logic             cpu_phi2,
  // Backplane inputs, asynchronous.
  input  wire logic        bp_reset_n,
  input  wire logic        bus_grant,
  input  wire logic        ext_ready,
  input  wire logic        periph_ready,
  input  wire logic        bp_rtc_line,
  input  wire logic [7:0]  bp_int_req,
  input  wire logic [7:0]  bp_din,
  // Backplane outputs.
  output logic             power_on_clear,
  output logic [7:0]       bp_status,
  output logic             bp_phi1,
  output logic             bp_phi2,
  output logic             bp_sync,
  output logic             bp_dbin,
  output logic             bp_wr_n,
  output logic             status_strobe,
  // On-board selects.
  output logic             onboard_select_n,
  output logic             rom_select_0,
  output logic             rom_select_1,
  output logic             rom_select_2,
  output logic             ram_select,
  output logic             port_select_serial,
  output logic             port_select_baud,
  output logic             port_select_rtc,
  output logic             port_select_step,
  output logic             serial_reg_sel,
  // Local interrupt sources.
  output logic             rtc_int,
  output logic             step_int
);

  localparam int unsigned NSYNC = 21;

  logic             phi1_w;
  logic             phi2_w;
  logic             phi1_rise;
  logic             phi2_rise;

  // Phase generator.
  cbg_clkgen u_clkgen (
    .clk       (clk),
    .rst       (rst),
    .phi1      (phi1_w),
    .phi2      (phi2_w),
    .phi1_rise (phi1_rise),
    .phi2_rise (phi2_rise)
  );

  // Two-stage synchronisers for every backplane input, one per bit.
  wire  [NSYNC-1:0] async_in = {bp_reset_n, bus_grant, ext_ready, periph_ready,
                                bp_rtc_line, bp_int_req, bp_din};
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= async_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  wire       s_reset_n = sync_ff[20];
  wire       s_grant   = sync_ff[19];
  wire       s_ext_ready    = sync_ff[18];
  wire       s_periph_ready    = sync_ff[17];
  wire       s_rtc     = sync_ff[16];
  wire [7:0] s_req     = sync_ff[15:8];
  wire [7:0] s_din     = sync_ff[7:0];

  // Power-on clear follows the backplane reset line, taken at phase one.
  logic poc_ff;
  logic cpu_reset_ff;
  wire  nxt_poc  = !s_reset_n;
  wire  glue_rst = rst || poc_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      poc_ff       <= 1'b1;
      cpu_reset_ff <= 1'b1;
    end else if (phi1_rise) begin
      poc_ff       <= nxt_poc;
      cpu_reset_ff <= nxt_poc;
    end
  end

  // Status strobe fires once, at the phase-one edge in the first state.
  logic       stb_ff;
  logic [7:0] status_ff;
  wire        nxt_stb = phi1_rise && cpu_sync;

  always_ff @(posedge clk) begin
    if (glue_rst) begin
      stb_ff    <= 1'b0;
      status_ff <= cbg_pkg::STATUS_RST;
    end else begin
      stb_ff <= nxt_stb;
      if (nxt_stb) begin
        status_ff <= cpu_dout;
      end
    end
  end

  // Cycle type from the held status; decoder enables from it and the high address bits.
  wire       st_int_ack_status  = status_ff[cbg_pkg::ST_INT_ACK_STATUS];
  wire       io_cycle = status_ff[cbg_pkg::ST_INP] || status_ff[cbg_pkg::ST_OUT];
  wire       onboard  = (cpu_addr[15:12] == cbg_pkg::ONBOARD_HIGH);
  wire       dec_en   = onboard && !st_int_ack_status;
  wire [2:0] dec_idx  = {io_cycle, cpu_addr[cbg_pkg::ADDR_A10+1], cpu_addr[cbg_pkg::ADDR_A10]};
  wire       dbin_act = cpu_dbin;

  // One-hot decode; the io bit in the index keeps ports and memory apart.
  wire hit_rom0   = dec_en && (dec_idx == cbg_pkg::SEL_ROM0);
  wire hit_rom1   = dec_en && (dec_idx == cbg_pkg::SEL_ROM1);
  wire hit_rom2   = dec_en && (dec_idx == cbg_pkg::SEL_ROM2);
  wire hit_ram    = dec_en && (dec_idx == cbg_pkg::SEL_RAM);
  wire hit_serial = dec_en && (dec_idx == cbg_pkg::SEL_SERIAL);
  wire hit_baud   = dec_en && (dec_idx == cbg_pkg::SEL_BAUD);
  wire hit_rtc    = dec_en && (dec_idx == cbg_pkg::SEL_RTC);
  wire hit_step   = dec_en && (dec_idx == cbg_pkg::SEL_STEP);

  // ROM selects are only for reads, so a stray write cannot drive the bus.
  wire nxt_rom0 = hit_rom0 && dbin_act;
  wire nxt_rom1 = hit_rom1 && dbin_act;
  wire nxt_rom2 = hit_rom2 && dbin_act;

  logic rom0_ff;
  logic rom1_ff;
  logic rom2_ff;
  logic ram_ff;
  logic ps_serial_ff;
  logic ps_baud_ff;
  logic ps_rtc_ff;
  logic ps_step_ff;
  logic a0_ff;
  logic onboard_select_n_n_ff;

  // Selects are registered; they trail the address by one fast clock.
  always_ff @(posedge clk) begin
    if (glue_rst) begin
      rom0_ff      <= 1'b0;
      rom1_ff      <= 1'b0;
      rom2_ff      <= 1'b0;
      ram_ff       <= 1'b0;
      ps_serial_ff <= 1'b0;
      ps_baud_ff   <= 1'b0;
      ps_rtc_ff    <= 1'b0;
      ps_step_ff   <= 1'b0;
      a0_ff        <= 1'b0;
      onboard_select_n_n_ff    <= 1'b1;
    end else begin
      rom0_ff      <= nxt_rom0;
      rom1_ff      <= nxt_rom1;
      rom2_ff      <= nxt_rom2;
      ram_ff       <= hit_ram;
      ps_serial_ff <= hit_serial;
      ps_baud_ff   <= hit_baud;
      ps_rtc_ff    <= hit_rtc;
      ps_step_ff   <= hit_step;
      a0_ff        <= cpu_addr[0];
      onboard_select_n_n_ff    <= !onboard;
    end
  end

  // Write start is the falling edge of the write strobe.
  logic wr_n_d_ff;
  logic dbin_d_ff;
  wire  wr_start = wr_n_d_ff && !cpu_wr_n;
  wire  dbin_end = dbin_d_ff && !cpu_dbin;

  always_ff @(posedge clk) begin
    if (glue_rst) begin
      wr_n_d_ff <= 1'b1;
      dbin_d_ff <= 1'b0;
    end else begin
      wr_n_d_ff <= cpu_wr_n;
      dbin_d_ff <= cpu_dbin;
    end
  end

  // A set wins over a clear; in reset the delay follows the line, so no false edge.
  logic rtc_d_ff;
  logic rtc_int_ff;
  wire  rtc_edge  = s_rtc && !rtc_d_ff;
  wire  rtc_clear = wr_start && hit_rtc;

  always_ff @(posedge clk) begin
    if (glue_rst) begin
      rtc_d_ff   <= s_rtc;
      rtc_int_ff <= 1'b0;
    end else begin
      rtc_d_ff <= s_rtc;
      if (rtc_edge) begin
        rtc_int_ff <= 1'b1;
      end else if (rtc_clear) begin
        rtc_int_ff <= 1'b0;
      end
    end
  end

  // Single step counts fetch strobes after arming, then interrupts.
  logic       step_arm_ff;
  logic [1:0] step_cnt_ff;
  logic       step_int_ff;
  wire        step_wr    = wr_start && hit_step;
  wire        fetch_stb  = nxt_stb && cpu_dout[cbg_pkg::ST_M1];
  wire        step_done  = dbin_end && st_int_ack_status && step_int_ff;
  wire [1:0]  nxt_cnt    = step_cnt_ff + 2'h1;
  wire        cnt_reach  = fetch_stb && (nxt_cnt == cbg_pkg::STEP_FETCHES);

  always_ff @(posedge clk) begin
    if (glue_rst || step_done) begin
      step_arm_ff <= 1'b0;
      step_cnt_ff <= 2'h0;
      step_int_ff <= 1'b0;
    end else if (step_wr) begin
      step_arm_ff <= 1'b1;
      step_cnt_ff <= 2'h0;
    end else if (step_arm_ff && !step_int_ff && fetch_stb) begin
      step_cnt_ff <= nxt_cnt;
      step_int_ff <= cnt_reach;
    end
  end

  // Priority encoder: highest request wins, vector n gives restart n.
  logic [2:0] enc_vec;
  logic       enc_any;
  always_comb begin
    enc_vec = 3'h0;
    enc_any = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (s_req[i]) begin
        enc_vec = 3'(i);
        enc_any = 1'b1;
      end
    end
  end

  // Armed single step masks the encoder so its own interrupt is next.
  wire       enc_on   = enc_any && !step_arm_ff;
  wire [7:0] rst_op   = cbg_pkg::RST_BASE | {2'b00, enc_vec, 3'b000};
  wire [7:0] nxt_din  = (st_int_ack_status && enc_on) ? rst_op : s_din;
  wire       nxt_int  = enc_on || step_int_ff;

  // Ready: on-board never waits; off-board waits for grant and both readies.
  wire       ready_cond = !onboard ? (s_grant && s_ext_ready && s_periph_ready) : 1'b1;

  logic       ready_ff;
  logic [7:0] din_ff;
  logic       int_ff;

  always_ff @(posedge clk) begin
    if (glue_rst) begin
      ready_ff <= 1'b0;
      din_ff   <= 8'h00;
      int_ff   <= 1'b0;
    end else begin
      if (phi2_rise) begin
        ready_ff <= ready_cond;
      end
      din_ff <= nxt_din;
      int_ff <= nxt_int;
    end
  end

  // Backplane copies of clocks and strobes, plus processor clock copies; one fast clock late.
  logic       phi1_bp_ff;
  logic       phi2_bp_ff;
  logic       sync_bp_ff;
  logic       dbin_bp_ff;
  logic       wr_n_bp_ff;
  logic       phi1_cpu_ff;
  logic       phi2_cpu_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      phi1_bp_ff  <= 1'b0;
      phi2_bp_ff  <= 1'b0;
      phi1_cpu_ff <= 1'b0;
      phi2_cpu_ff <= 1'b0;
      sync_bp_ff  <= 1'b0;
      dbin_bp_ff  <= 1'b0;
      wr_n_bp_ff  <= 1'b1;
    end else begin
      phi1_bp_ff  <= phi1_w;
      phi2_bp_ff  <= phi2_w;
      phi1_cpu_ff <= phi1_w;
      phi2_cpu_ff <= phi2_w;
      sync_bp_ff  <= cpu_sync;
      dbin_bp_ff  <= cpu_dbin;
      wr_n_bp_ff  <= cpu_wr_n;
    end
  end

  // Port connections.
  assign cpu_din            = din_ff;
  assign cpu_ready          = ready_ff;
  assign cpu_reset          = cpu_reset_ff;
  assign cpu_int            = int_ff;
  assign cpu_phi1           = phi1_cpu_ff;
  assign cpu_phi2           = phi2_cpu_ff;
  assign power_on_clear     = poc_ff;
  assign bp_status          = status_ff;
  assign bp_phi1            = phi1_bp_ff;
  assign bp_phi2            = phi2_bp_ff;
  assign bp_sync            = sync_bp_ff;
  assign bp_dbin            = dbin_bp_ff;
  assign bp_wr_n            = wr_n_bp_ff;
  assign status_strobe      = stb_ff;
  assign onboard_select_n   = onboard_select_n_n_ff;
  assign rom_select_0       = rom0_ff;
  assign rom_select_1       = rom1_ff;
  assign rom_select_2       = rom2_ff;
  assign ram_select         = ram_ff;
  assign port_select_serial = ps_serial_ff;
  assign port_select_baud   = ps_baud_ff;
  assign port_select_rtc    = ps_rtc_ff;
  assign port_select_step   = ps_step_ff;
  assign serial_reg_sel     = a0_ff;
  assign rtc_int            = rtc_int_ff;
  assign step_int           = step_int_ff;

endmodule : cbg_glue

// *** verif/cbg_glue_props.sv ***
`timescale 1ns/1ps
module cbg_glue_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Processor side.
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  cpu_dout,
  input wire logic        cpu_sync,
  input wire logic        cpu_dbin,
  input wire logic        cpu_wr_n,
  input wire logic        cpu_phi1,
  input wire logic        cpu_phi2,
  // Backplane side.
  input wire logic        power_on_clear,
  input wire logic [7:0]  bp_status,
  input wire logic        bp_phi1,
  input wire logic        bp_phi2,
  input wire logic        bp_sync,
  input wire logic        bp_dbin,
  input wire logic        bp_wr_n,
  input wire logic        status_strobe,
  // Selects.
  input wire logic        onboard_select_n,
  input wire logic        rom_select_0,
  input wire logic        rom_select_1,
  input wire logic        rom_select_2,
  input wire logic        ram_select,
  input wire logic        port_select_serial,
  input wire logic        port_select_baud,
  input wire logic        port_select_rtc,
  input wire logic        port_select_step
);
  // All eight decoder outputs, highest index first.
  wire [7:0] sels = {port_select_step, port_select_rtc, port_select_baud, port_select_serial,
                     ram_select, rom_select_2, rom_select_1, rom_select_0};

  default clocking dck @(posedge clk);
  endclocking
  default disable iff (rst);

  // Phase shape: apart, second-phase width of five counts, period of nine.
  AST_PHASE_APART: assert property (!(cpu_phi1 && cpu_phi2))
    else $error("clock phases overlap");
  AST_PHI2_WIDTH: assert property ($rose(cpu_phi2) |-> cpu_phi2[*5] ##1 !cpu_phi2)
    else $error("second phase width wrong");
  AST_PERIOD: assert property ($rose(cpu_phi1) |-> ##9 $rose(cpu_phi1))
    else $error("phase period is not nine clocks");
  AST_BP_PHASE: assert property ({bp_phi1, bp_phi2} == {cpu_phi1, cpu_phi2})
    else $error("backplane phases differ from processor phases");
  // Status capture is a single pulse after a sync and carries the word on.
  AST_STROBE: assert property (status_strobe |-> $past(cpu_sync) ##1 !status_strobe)
    else $error("status strobe shape wrong");
  AST_STATUS: assert property (status_strobe |-> bp_status == $past(cpu_dout))
    else $error("latched status differs from processor word");
  AST_COPY: assert property (
    {bp_sync, bp_dbin, bp_wr_n} == $past({cpu_sync, cpu_dbin, cpu_wr_n}))
    else $error("buffered strobes differ");
  // Decoder relations; the clear only lets go once the hold has ended.
  AST_ONBOARD: assert property (!$past(power_on_clear) |->
    onboard_select_n == ($past(cpu_addr[15:12]) != cbg_pkg::ONBOARD_HIGH))
    else $error("onboard select wrong");
  AST_EXCL: assert property ($onehot0(sels))
    else $error("more than one select active");
  AST_ROM_DBIN: assert property (|sels[2:0] |-> $past(cpu_dbin))
    else $error("rom select without data-in");
  AST_INT_ACK_STATUS: assert property ($past(bp_status[cbg_pkg::ST_INT_ACK_STATUS]) |-> sels == 8'h00)
    else $error("select during interrupt acknowledge");
  AST_POC: assert property ($past(power_on_clear) |-> sels == 8'h00)
    else $error("select while power-on clear");
endmodule : cbg_glue_props

bind cbg_glue cbg_glue_props u_props (
  .clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_dout(cpu_dout), .cpu_sync(cpu_sync),
  .cpu_dbin(cpu_dbin), .cpu_wr_n(cpu_wr_n), .cpu_phi1(cpu_phi1), .cpu_phi2(cpu_phi2),
  .power_on_clear(power_on_clear), .bp_status(bp_status), .bp_sync(bp_sync),
  .bp_phi1(bp_phi1), .bp_phi2(bp_phi2),
  .bp_dbin(bp_dbin), .bp_wr_n(bp_wr_n), .status_strobe(status_strobe),
  .onboard_select_n(onboard_select_n), .rom_select_0(rom_select_0),
  .rom_select_1(rom_select_1), .rom_select_2(rom_select_2), .ram_select(ram_select),
  .port_select_serial(port_select_serial), .port_select_baud(port_select_baud),
  .port_select_rtc(port_select_rtc), .port_select_step(port_select_step)
);

// *** verif/cbg_bp_model.sv ***
`timescale 1ns/1ps
module cbg_bp_model (
  // Clock.
  input  wire logic       clk,
  // Cycle as the card shows it.
  input  wire logic       onboard_select_n,
  input  wire logic       cpu_dbin,
  input  wire logic [7:0] rd_data,
  input  wire logic [4:0] lat,
  // Backplane answer.
  output logic            bus_grant,
  output logic            ext_ready,
  output logic            periph_ready,
  output logic [7:0]      bp_din
);
  logic [4:0] cnt_ff;

  initial begin
    cnt_ff = 5'h00;
    {bus_grant, ext_ready, periph_ready} = 3'h0;
    bp_din = 8'h00;
  end

  // Grant and ready come only after the programmed wait; an idle bus toggles
  // its data so a stale byte can never pass for a fresh one.
  always @(negedge clk) begin
    if (onboard_select_n && cpu_dbin && cnt_ff >= lat) begin
      {bus_grant, ext_ready, periph_ready} <= 3'h7;
      bp_din <= rd_data;
    end else begin
      {bus_grant, ext_ready, periph_ready} <= 3'h0;
      bp_din <= ~bp_din;
    end
    cnt_ff <= (onboard_select_n && cpu_dbin) ? cnt_ff + ((cnt_ff < lat) ? 5'h01 : 5'h00) : 5'h00;
  end
endmodule : cbg_bp_model

// *** verif/test_cpu_board_glue_decode.sv ***
`timescale 1ns/1ps
module test_cpu_board_glue_decode;
  logic        clk, rst, cpu_sync, cpu_dbin, cpu_wr_n, bp_reset_n, bp_rtc_line;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_dout, bp_int_req, rd_data;
  logic [4:0]  lat;
  wire  [7:0]  cpu_din, bp_status, bp_din;
  wire         cpu_ready, cpu_reset, cpu_int, power_on_clear, status_strobe, onboard_select_n;
  wire         rom_select_0, rom_select_1, rom_select_2, ram_select, serial_reg_sel;
  wire         port_select_serial, port_select_baud, port_select_rtc, port_select_step;
  wire         rtc_int, step_int, bus_grant, ext_ready, periph_ready;
  int          n_mismatch, total_checks, cyc_cnt;
  wire  [7:0]  sels = {port_select_step, port_select_rtc, port_select_baud, port_select_serial,
                       ram_select, rom_select_2, rom_select_1, rom_select_0};

  cbg_glue uut (
    .clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_dout(cpu_dout), .cpu_sync(cpu_sync),
    .cpu_dbin(cpu_dbin), .cpu_wr_n(cpu_wr_n), .cpu_din(cpu_din), .cpu_ready(cpu_ready),
    .cpu_reset(cpu_reset), .cpu_int(cpu_int), .cpu_phi1(), .cpu_phi2(),
    .bp_reset_n(bp_reset_n), .bus_grant(bus_grant), .ext_ready(ext_ready),
    .periph_ready(periph_ready), .bp_rtc_line(bp_rtc_line), .bp_int_req(bp_int_req),
    .bp_din(bp_din), .power_on_clear(power_on_clear), .bp_status(bp_status), .bp_phi1(),
    .bp_phi2(), .bp_sync(), .bp_dbin(), .bp_wr_n(), .status_strobe(status_strobe),
    .onboard_select_n(onboard_select_n), .rom_select_0(rom_select_0),
    .rom_select_1(rom_select_1), .rom_select_2(rom_select_2), .ram_select(ram_select),
    .port_select_serial(port_select_serial), .port_select_baud(port_select_baud),
    .port_select_rtc(port_select_rtc), .port_select_step(port_select_step),
    .serial_reg_sel(serial_reg_sel), .rtc_int(rtc_int), .step_int(step_int)
  );

  cbg_bp_model u_bp (
    .clk(clk), .onboard_select_n(onboard_select_n), .cpu_dbin(cpu_dbin),
    .rd_data(rd_data), .lat(lat), .bus_grant(bus_grant), .ext_ready(ext_ready),
    .periph_ready(periph_ready), .bp_din(bp_din)
  );

  // Free-running 125 MHz clock and a hang guard at 8000 cycles, well beyond the few hundred cycles used.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One machine cycle: release the last strobes, present status until it is latched,
  // then hold address with data-in and, two clocks later, the write strobe.
  task automatic cyc_run(input logic [7:0] st, input logic [15:0] a, input logic rd,
                         input logic wr);
    cpu_dbin = 1'b0;
    cpu_wr_n = 1'b1;
    repeat (2) @(negedge clk);
    cpu_addr = a;
    cpu_dout = st;
    cpu_sync = 1'b1;
    for (int i = 0; i < 20 && status_strobe !== 1'b1; i++) @(negedge clk);
    chk("status", st, bp_status);
    cpu_sync = 1'b0;
    cpu_dbin = rd;
    repeat (2) @(negedge clk);
    cpu_wr_n = ~wr;
    repeat (4) @(negedge clk);
  endtask : cyc_run

  task automatic t_decode();
    logic [7:0] p;
    for (int i = 0; i < 8; i++) begin
      p = {4'h0, 2'(i), 2'h3};
      if (i >= 4) begin
        cyc_run((i % 2) ? 8'h10 : 8'h42, {p, p}, 1'b0, 1'b0);
        chk("port selects", 8'h01 << i, sels);
      end else begin
        cyc_run(8'h82, {4'h0, 2'(i), 10'h3FF}, 1'b1, 1'b0);
        chk("memory selects", 8'h01 << i, sels);
      end
      if (i == 4) chk("serial_reg_sel", 8'h01, serial_reg_sel);
    end
    cyc_run(8'h82, 16'h1000, 1'b1, 1'b0);
    chk("onboard_select_n", 8'h01, onboard_select_n);
    chk("selects", 8'h00, sels);
    cyc_run(8'h82, 16'h0000, 1'b0, 1'b0);
    chk("selects", 8'h00, sels);
    $display("decode test done");
  endtask : t_decode

  task automatic t_ready();
    cyc_run(8'h82, 16'h2000, 1'b1, 1'b0);
    repeat (9) @(negedge clk);
    chk("cpu_ready", 8'h00, cpu_ready);
    for (int i = 0; i < 40 && cpu_ready !== 1'b1; i++) @(negedge clk);
    chk("cpu_ready", 8'h01, cpu_ready);
    repeat (3) @(negedge clk);
    chk("cpu_din", rd_data, cpu_din);
    cyc_run(8'h82, 16'h0C00, 1'b1, 1'b0);
    chk("selects", 8'h08, sels);
    for (int i = 0; i < 20 && cpu_ready !== 1'b1; i++) @(negedge clk);
    chk("cpu_ready", 8'h01, cpu_ready);
    $display("ready test done");
  endtask : t_ready

  task automatic t_intr();
    for (int n = 0; n < 8; n++) begin
      bp_int_req = (8'h01 << n) | 8'h01;
      cyc_run(8'h23, 16'h0000, 1'b1, 1'b0);
      chk("cpu_int", 8'h01, cpu_int);
      chk("cpu_din", {2'b11, 3'(n), 3'b111}, cpu_din);
      chk("selects", 8'h00, sels);
    end
    bp_int_req = 8'h00;
    $display("interrupt test done");
  endtask : t_intr

  task automatic t_local();
    bp_rtc_line = 1'b1;
    repeat (6) @(negedge clk);
    chk("rtc_int", 8'h01, rtc_int);
    cyc_run(8'h10, 16'h0808, 1'b0, 1'b1);
    chk("rtc_int", 8'h00, rtc_int);
    chk("cpu_int", 8'h00, cpu_int);
    cyc_run(8'h10, 16'h0C0C, 1'b0, 1'b1);
    cyc_run(8'hA2, 16'h0000, 1'b1, 1'b0);
    chk("step_int", 8'h00, step_int);
    cyc_run(8'hA2, 16'h0001, 1'b1, 1'b0);
    chk("step_int", 8'h01, step_int);
    chk("cpu_int", 8'h01, cpu_int);
    cyc_run(8'h23, 16'h0000, 1'b1, 1'b0);
    cyc_run(8'h82, 16'h0000, 1'b1, 1'b0);
    chk("step_int", 8'h00, step_int);
    $display("local interrupt test done");
  endtask : t_local

  task automatic t_reset();
    bp_reset_n = 1'b0;
    for (int i = 0; i < 20 && power_on_clear !== 1'b1; i++) @(negedge clk);
    chk("power_on_clear", 8'h01, power_on_clear);
    repeat (12) @(negedge clk);
    chk("cpu_reset", 8'h01, cpu_reset);
    chk("bp_status", 8'h00, bp_status);
    bp_reset_n = 1'b1;
    for (int i = 0; i < 30 && power_on_clear !== 1'b0; i++) @(negedge clk);
    chk("power_on_clear", 8'h00, power_on_clear);
    repeat (12) @(negedge clk);
    chk("cpu_reset", 8'h00, cpu_reset);
    $display("reset test done");
  endtask : t_reset

  // Main sequence: everything driven at the falling edge.
  initial begin
    {clk, rst, cpu_sync, cpu_dbin, cpu_wr_n, bp_reset_n, bp_rtc_line} = 7'b0100110;
    {cpu_addr, cpu_dout, bp_int_req} = 32'h0;
    rd_data = 8'h5A;
    lat = 5'd20;
    {n_mismatch, total_checks, cyc_cnt} = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 40 && power_on_clear !== 1'b0; i++) @(negedge clk);
    t_decode();
    t_ready();
    t_intr();
    t_local();
    t_reset();
    end_sim();
  end
endmodule : test_cpu_board_glue_decode
